/* File: uvd_pkg.sv */
// Package for the undervoltage detector control block
// Assumes a classic Wishbone slave with 32-bit data, byte offsets

package uvd_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [3:0] ADDR_MODE   = 4'h0;
    localparam logic [3:0] ADDR_LEVEL  = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_MASK   = 4'hc;

    // ----------------------------------------
    // Mode register fields
    // ----------------------------------------
    localparam int MODE_ON_BIT  = 7;
    localparam int MODE_SRC_BIT = 2;
    localparam int MODE_RST_BIT = 1;
    localparam int MODE_FLG_BIT = 0;

    // ----------------------------------------
    // Field widths and reset values
    // ----------------------------------------
    localparam int LEVEL_W = 4;
    localparam logic [7:0] MODE_RST_VAL  = 8'h00;
    localparam logic [3:0] LEVEL_RST_VAL = 4'h7;
    localparam logic [1:0] MASK_RST_VAL  = 2'h3;

    // Status bits: detect event, reset event
    localparam int STS_DET_BIT = 0;
    localparam int STS_RST_BIT = 1;

    // External source threshold in millivolts
    localparam int EXT_THRESH_MV = 1210;

    typedef enum logic [1:0] {
        UVD_IDLE,
        UVD_ARMED,
        UVD_LOW
    } uvd_state_t;

endpackage

/* File: uvd_sync.sv */
// Three-stage synchroniser with agreement filter
// Assumes input is asynchronous to clk_i

`timescale 1ns/10ps

module uvd_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Data
    input  wire logic d_i,
    output logic      q_o
);

    logic s1_r, s2_r, s3_r, q_r;
    logic q_nxt;

    // Change only when stages two and three agree
    always_comb begin
        q_nxt = (s2_r == s3_r) ? s3_r : q_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r  <= 1'b0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q_o = q_r;

endmodule

/* File: uvd_ctrl.sv */
// Undervoltage detector control: registers, source select, reset and irq
// Assumes analog comparators outside; their outputs arrive as async levels
// How it works
// - Writing 00h to mode, or clearing the on bit, stops detection.
// - External source uses fixed 1.21 V threshold; level select ignored.
// - Reset mode asserts internal reset only while voltage is below threshold.
// - Unmasked detection may interrupt right after start-up completes.
// - Own internal reset never clears these registers; system reset does.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.

`timescale 1ns/10ps

module uvd_ctrl (
    // Clock and system reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Comparators
    input  wire logic        supply_below_i,
    input  wire logic        ext_below_i,
    // Level select, source select and comparator enable to the analog side
    output logic [3:0]       level_sel_o,
    output logic             ext_src_o,
    output logic             cmp_en_o,
    // Results
    output logic             uvd_reset_o,
    output logic             irq_o
);

    // ----------------------------------------
    // Comparator synchronisers
    // ----------------------------------------
    logic sup_low, ext_low;

    uvd_sync u_sync_sup (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (supply_below_i),
        .q_o   (sup_low)
    );

    uvd_sync u_sync_ext (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (ext_below_i),
        .q_o   (ext_low)
    );

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0]             mode_r, mode_nxt;
    logic [3:0]             level_r, level_nxt;
    logic [1:0]             sts_r, sts_nxt;
    logic [1:0]             mask_r, mask_nxt;
    logic                   ack_r, ack_nxt;
    logic [31:0]            dat_r, dat_nxt;
    uvd_pkg::uvd_state_t    st_r, st_nxt;

    logic wr, rd, below, on, rst_mode;

    assign wr       = cyc_i & stb_i & we_i & ~ack_r;
    assign rd       = cyc_i & stb_i & ~we_i & ~ack_r;
    assign on       = mode_r[uvd_pkg::MODE_ON_BIT];
    assign rst_mode = mode_r[uvd_pkg::MODE_RST_BIT];

    assign below = mode_r[uvd_pkg::MODE_SRC_BIT] ? ext_low : sup_low;

    // ----------------------------------------
    // Detector state machine
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            uvd_pkg::UVD_IDLE: begin
                if (on) begin
                    st_nxt = uvd_pkg::UVD_ARMED;
                end
            end
            uvd_pkg::UVD_ARMED: begin
                if (!on) begin
                    st_nxt = uvd_pkg::UVD_IDLE;
                end else if (below) begin
                    st_nxt = uvd_pkg::UVD_LOW;
                end
            end
            uvd_pkg::UVD_LOW: begin
                if (!on) begin
                    st_nxt = uvd_pkg::UVD_IDLE;
                end else if (!below) begin
                    st_nxt = uvd_pkg::UVD_ARMED;
                end
            end
            default: st_nxt = uvd_pkg::UVD_IDLE;
        endcase
    end

    logic det_evt;
    // Detection fires as soon as armed and low
    assign det_evt = (st_r == uvd_pkg::UVD_ARMED) && on && below;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_comb begin
        mode_nxt  = mode_r;
        level_nxt = level_r;
        mask_nxt  = mask_r;
        sts_nxt   = sts_r;
        ack_nxt   = cyc_i & stb_i & ~ack_r;
        dat_nxt   = dat_r;
        if (wr && sel_i[0]) begin
            case (adr_i)
                // Byte write of 00h or on-bit clear stops detection
                uvd_pkg::ADDR_MODE:   mode_nxt  = dat_i[7:0] & 8'h86;
                // Upper bits dropped; software keeps level stable
                uvd_pkg::ADDR_LEVEL:  level_nxt = dat_i[3:0];
                uvd_pkg::ADDR_STATUS: sts_nxt   = sts_r & ~dat_i[1:0];
                uvd_pkg::ADDR_MASK:   mask_nxt  = dat_i[1:0];
                default: ;
            endcase
        end
        // Set wins over clear
        if (det_evt) begin
            sts_nxt[uvd_pkg::STS_DET_BIT] = 1'b1;
        end
        if (det_evt && rst_mode) begin
            sts_nxt[uvd_pkg::STS_RST_BIT] = 1'b1;
        end
        if (rd) begin
            case (adr_i)
                uvd_pkg::ADDR_MODE:   dat_nxt = {24'h000000, mode_r[7:1],
                                                 (st_r == uvd_pkg::UVD_LOW)};
                uvd_pkg::ADDR_LEVEL:  dat_nxt = {28'h0000000, level_r};
                uvd_pkg::ADDR_STATUS: dat_nxt = {30'h00000000, sts_r};
                uvd_pkg::ADDR_MASK:   dat_nxt = {30'h00000000, mask_r};
                default:              dat_nxt = 32'h00000000;
            endcase
        end
    end

    // Only system reset clears; own reset output never feeds back
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r  <= uvd_pkg::MODE_RST_VAL;
            level_r <= uvd_pkg::LEVEL_RST_VAL;
            mask_r  <= uvd_pkg::MASK_RST_VAL;
            sts_r   <= 2'h0;
            ack_r   <= 1'b0;
            dat_r   <= 32'h00000000;
            st_r    <= uvd_pkg::UVD_IDLE;
        end else begin
            mode_r  <= mode_nxt;
            level_r <= level_nxt;
            mask_r  <= mask_nxt;
            sts_r   <= sts_nxt;
            ack_r   <= ack_nxt;
            dat_r   <= dat_nxt;
            st_r    <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ack_o       = ack_r;
    assign dat_o       = dat_r;
    assign level_sel_o = level_r;
    assign ext_src_o   = mode_r[uvd_pkg::MODE_SRC_BIT];
    assign cmp_en_o    = on;
    // Reset only while low in reset mode
    assign uvd_reset_o = on && rst_mode && (st_r == uvd_pkg::UVD_LOW);
    assign irq_o       = |(sts_r & ~mask_r);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    mode_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && sel_i[0] && adr_i == uvd_pkg::ADDR_MODE && !dat_i[7])
        |=> !cmp_en_o ##1 (st_r == uvd_pkg::UVD_IDLE))
        else $error("detector did not stop");

    reset_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        uvd_reset_o |-> (rst_mode && on && $past(below)))
        else $error("reset without low voltage");

    reset_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (on && !below) |=> !uvd_reset_o)
        else $error("reset while voltage good");

    ext_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ext_src_o && on && !ext_low && $stable(ext_low) && sup_low)
        |=> !uvd_reset_o)
        else $error("supply used with external source");

    det_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (det_evt && !mask_r[uvd_pkg::STS_DET_BIT]
         && !(wr && adr_i == uvd_pkg::ADDR_MASK)) |=> irq_o)
        else $error("unmasked detection gave no irq");

    sticky_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        det_evt |=> sts_r[uvd_pkg::STS_DET_BIT])
        else $error("detection flag lost");

    self_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (uvd_reset_o && !wr) |=> $stable(mode_r) && $stable(level_r))
        else $error("registers changed by own reset");

    sync_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sup_low) |-> ($past(supply_below_i, 3) && $past(supply_below_i, 4)))
        else $error("synchronised low not seen");

endmodule

/* File: uvd_ctrl_tb_top.sv */
// Testbench for the undervoltage detector control block
// Assumes uvd_ctrl carries its own assertions; bench drives all ports

`timescale 1ns/10ps

module uvd_ctrl_tb_top;

    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic        sup_i = 1'b0;
    logic        ext_i = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [3:0]  level_sel_o;
    logic        ext_src_o;
    logic        cmp_en_o;
    logic        uvd_reset_o;
    logic        irq_o;
    int          err_total = 0;
    int          tests_run = 0;
    logic [31:0] rd;

    uvd_ctrl u_uvd_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .supply_below_i(sup_i), .ext_below_i(ext_i), .level_sel_o(level_sel_o),
        .ext_src_o(ext_src_o), .cmp_en_o(cmp_en_o), .uvd_reset_o(uvd_reset_o),
        .irq_o(irq_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Request held until ack is sampled high; one idle cycle after
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
        if (n >= 50) begin
            $display("Error bus ack expected 1 seen timeout");
            err_total++;
            give_verdict;
        end
    endtask

    // Sync latency is not fixed, so wait bounded
    task automatic wait_lvl(input string nm, input logic s, input logic v);
        int n;
        n = 0;
        while ((s ? irq_o : uvd_reset_o) !== v && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk(nm, {31'h0, v}, {31'h0, s ? irq_o : uvd_reset_o});
        if (n >= 20) begin
            give_verdict;
        end
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs;
        wb(0, 4'h0, 0); chk("mode rst", 32'h0, rd);
        wb(0, 4'h4, 0); chk("level rst", 32'h7, rd);
        wb(0, 4'hc, 0); chk("mask rst", 32'h3, rd);
        wb(1, 4'h4, 32'h5);
        wb(0, 4'h4, 0); chk("level rw", 32'h5, rd);
        chk("level out", 32'h5, {28'h0, level_sel_o});
        wb(0, 4'h2, 0); chk("unmapped", 32'h0, rd);
    endtask

    task automatic t_irq;
        wb(1, 4'hc, 32'h0);
        wb(1, 4'h0, 32'h80);
        sup_i <= 1'b1;
        wait_lvl("irq set", 1, 1);
        wb(0, 4'h8, 0); chk("status", 32'h1, rd & 32'h3);
        wb(1, 4'hc, 32'h3);
        wait_lvl("irq masked", 1, 0);
        wb(1, 4'hc, 32'h0);
        wait_lvl("irq unmask", 1, 1);
        sup_i <= 1'b0;
        wb(1, 4'h8, 32'h3);
        wait_lvl("irq clear", 1, 0);
        chk("no reset", 32'h0, {31'h0, uvd_reset_o});
    endtask

    task automatic t_rst_mode;
        wb(1, 4'h0, 32'h82);
        repeat (10) @(posedge clk_i);
        chk("rst above", 32'h0, {31'h0, uvd_reset_o});
        sup_i <= 1'b1;
        wait_lvl("rst below", 0, 1);
        wb(0, 4'h0, 0); chk("mode kept", 32'h82, rd & 32'h86);
        wb(0, 4'h8, 0); chk("status rst", 32'h3, rd);
        chk("cmp on", 32'h1, {31'h0, cmp_en_o});
        sup_i <= 1'b0;
        wait_lvl("rst release", 0, 0);
    endtask

    task automatic t_ext;
        sup_i <= 1'b1;
        wb(1, 4'h0, 32'h86);
        repeat (10) @(posedge clk_i);
        chk("ext ignore sup", 32'h0, {31'h0, uvd_reset_o});
        chk("ext src", 32'h1, {31'h0, ext_src_o});
        ext_i <= 1'b1;
        wait_lvl("ext below", 0, 1);
        ext_i <= 1'b0;
        wait_lvl("ext above", 0, 0);
    endtask

    task automatic t_stop;
        wb(1, 4'h0, 32'h82);
        wait_lvl("restart", 0, 1);
        wb(1, 4'h0, 32'h02);
        wait_lvl("bit stop", 0, 0);
        chk("cmp off", 32'h0, {31'h0, cmp_en_o});
        wb(1, 4'h0, 32'h82);
        wait_lvl("rerun", 0, 1);
        wb(1, 4'h0, 32'h00);
        wait_lvl("byte stop", 0, 0);
        wb(0, 4'h0, 0); chk("mode off", 32'h0, rd & 32'h86);
        sup_i <= 1'b0;
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_irq;
        t_rst_mode;
        t_ext;
        t_stop;
        give_verdict;
    end

endmodule
